// ===== include/tla_consts.svh
// Constants of the temperature alarm logger: register page offsets,
// field positions, alarm area layout and timing figures.
// Assumes inclusion by bare name from both ends.
`ifndef TLA_CONSTS_SVH
`define TLA_CONSTS_SVH
`define TLA_CLK_HZ 64'd200000000
`define TLA_MINUTE_S 64'd60
`define TLA_ALARM_BASE 16'h0220
`define TLA_ALARM_END 16'h027f
`define TLA_ALARM_REL_BASE 7'h20
`define TLA_ALARM_HIGH_REL 7'h30
`define TLA_REG_TH_LOW 16'h020b
`define TLA_REG_TH_HIGH 16'h020c
`define TLA_REG_RATE 16'h020d
`define TLA_REG_CTRL 16'h020e
`define TLA_REG_DELAY_LO 16'h0212
`define TLA_REG_DELAY_HI 16'h0213
`define TLA_REG_STATUS 16'h0214
`define TLA_REG_STAMP 16'h0215
`define TLA_REG_MCNT 16'h021a
`define TLA_REG_DCNT 16'h021d
`define TLA_PROT_BASE 16'h0200
`define TLA_PROT_END 16'h0213
`define TLA_CTRL_SRCH_LOW 0
`define TLA_CTRL_SRCH_HIGH 1
`define TLA_CTRL_WRAP 3
`define TLA_CTRL_EN_N 4
`define TLA_CTRL_OSC_N 7
`define TLA_ST_LOW 0
`define TLA_ST_HIGH 1
`define TLA_ST_ACTIVE 5
`define TLA_ST_CLEARED 6
`define TLA_DUR_MAX 8'hff
`define TLA_SP_PREAMBLE 6'h03
`define TLA_HOST_ADDR 3'h0
`define TLA_HOST_DATA 3'h1
`define TLA_HOST_CMD 3'h2
`define TLA_HOST_RESP 3'h3
`define TLA_HOST_STATUS 3'h4
`endif

// ===== include/tla_pkg.sv
// Types shared by both ends of the logger link.
// Assumes tla_consts.svh sits on the include path.
`default_nettype none
package tla_pkg;
	// Link commands, one per request pulse
	typedef enum logic [2:0] {
		TLA_NOP = 3'h0,
		TLA_WRSP = 3'h1,
		TLA_SPDATA = 3'h2,
		TLA_SPPART = 3'h3,
		TLA_RDSP = 3'h4,
		TLA_COPY = 3'h5,
		TLA_RDMEM = 3'h6,
		TLA_CLEAR = 3'h7
	} tla_cmd_t;
	// Mission sequencer, Gray along idle, delay, run
	typedef enum logic [1:0] {
		TLA_IDLE = 2'b00,
		TLA_DELAY = 2'b01,
		TLA_RUN = 2'b11
	} tla_mstate_t;
endpackage
`default_nettype wire

// ===== include/tla_link_if.sv
// Link between the bus master end and the logger end.
// Assumes both ends share i_clk_sys; the bench joins them.
`default_nettype none
interface tla_link_if;
	import tla_pkg::*;
	logic req;
	tla_cmd_t cmd;
	logic [15:0] addr;
	logic [7:0] data;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic busy;
	modport dev (input req, input cmd, input addr, input data,
		output rsp_valid, output rsp_data, output busy);
	modport host (output req, output cmd, output addr, output data,
		input rsp_valid, input rsp_data, input busy);
endinterface
`default_nettype wire

// ===== hdl/tla_device.sv
// Logger end: mission sequencing, alarm record area, address registers
// and scratchpad. Assumes link requests are one-cycle pulses synchronous
// to i_clk_sys and that none arrive while busy is high.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`include "tla_consts.svh"
`default_nettype none
// Behaviour
// - Alarm records live only in 0220h-027Fh
// - Twelve low entries, then twelve high entries
// - Entry opens with three-byte sample count
// - Byte after timestamp counts out-of-band samples
// - Full counter opens next entry if still alarming
// - Return to band freezes; next crossing, next entry
// - Alarm flags qualify search per control bits
// - Search bits never touch mission or logging
// - Master sets clock, oscillator running one second
// - Master clears memory and alarm flags first
// - Mission needs mission-enable flag at zero
// - Sample rate written last, 1 to 255
// - Rate write sets active, clears cleared flag
// - Delay, minute boundary, stamp, first conversion
// - Each conversion bumps mission and device counts
// - Later samples every rate minutes on boundaries
// - Wraparound choice is the master's; TLA_CTRL_WRAP is ignored here and a full alarm area takes no more entries
// - Target address registers give transfer address
// - Status byte read-only, low five ending offset
// - Partial byte flag bit 5, bit 6 zero
// - Target low bits set scratchpad start offset
// - Copy sets top bit; scratchpad write clears
// - Sample at threshold sets matching alarm flag
module tla_device import tla_pkg::*; #(
	parameter longint unsigned MINUTE_CYCLES = `TLA_MINUTE_S * `TLA_CLK_HZ,
	parameter int ENTRIES = 12
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	tla_link_if.dev link,
	input wire logic [7:0] i_temp,
	output logic o_sample,
	output logic o_mission_active,
	output logic o_search_hit
);
	localparam int AB = 4 * ENTRIES;
	logic [7:0] sp [0:31];
	logic [7:0] alarm_mem [0:1][0:AB-1];
	logic [15:0] ta;
	logic [4:0] es_off;
	logic [5:0] wptr;
	logic pf, aa, copying;
	logic [4:0] cptr;
	logic [15:0] caddr;
	logic [7:0] th_low, th_high, srate, ctrl, delay_lo, delay_hi;
	logic flag_low, flag_high, mission_active, cleared_flag;
	logic [31:0] rtc_min, stamp;
	logic [23:0] mcnt, dcnt;
	logic [15:0] delay_cnt;
	logic [7:0] rate_cnt;
	logic [35:0] min_cnt;
	tla_mstate_t mstate;
	logic [3:0] idx [0:1];
	logic in_alarm [0:1];
	logic [7:0] rsp_data;
	logic rsp_valid;

	// Request decode; every command, reads included, is held off while copying
	wire live = link.req && !copying;
	wire do_wrsp = live && link.cmd == TLA_WRSP;
	wire do_spdata = live && link.cmd == TLA_SPDATA && !wptr[5];
	wire do_sppart = live && link.cmd == TLA_SPPART;
	wire do_rdmem = live && link.cmd == TLA_RDMEM;
	wire do_rdsp = live && link.cmd == TLA_RDSP;
	wire do_clear = live && link.cmd == TLA_CLEAR && !mission_active;
	wire [7:0] es_byte = {aa, 1'b0, pf, es_off};
	wire do_copy = live && link.cmd == TLA_COPY && link.addr == ta && link.data == es_byte;

	// Copy engine writes one byte per cycle into the register page
	wire [7:0] cwd = sp[cptr];
	wire in_prot = caddr >= `TLA_PROT_BASE && caddr <= `TLA_PROT_END;
	wire end_mission = copying && mission_active && in_prot;
	wire cwr = copying && !(mission_active && in_prot);
	wire wr_rate = cwr && caddr == `TLA_REG_RATE;
	wire start = wr_rate && !mission_active && !ctrl[`TLA_CTRL_EN_N] && cwd != 8'h00;
	wire wr_status = cwr && caddr == `TLA_REG_STATUS;

	// Minute boundary only while the oscillator runs
	wire osc_run = !ctrl[`TLA_CTRL_OSC_N];
	wire tick = osc_run && min_cnt == MINUTE_CYCLES[35:0] - 36'd1;
	wire first = tick && mstate == TLA_DELAY && delay_cnt == 16'h0000;
	wire sample = first || (tick && mstate == TLA_RUN && rate_cnt == 8'h01);
	wire [23:0] next_mcnt = mcnt + 24'd1;
	wire hit [0:1];
	assign hit[0] = i_temp <= th_low;
	assign hit[1] = i_temp >= th_high;

	// Entry bases: next free slot and the slot being counted
	logic [5:0] open_base [0:1];
	logic [5:0] cur_base [0:1];
	logic dur_full [0:1];
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			open_base[k] = {idx[k], 2'b00};
			cur_base[k] = {idx[k] - 4'd1, 2'b00};
			dur_full[k] = alarm_mem[k][cur_base[k] + 6'd3] == `TLA_DUR_MAX;
		end
	end

	// Memory read decode for read commands
	wire [6:0] arel = link.addr[6:0] - `TLA_ALARM_REL_BASE;
	wire akind = arel >= `TLA_ALARM_HIGH_REL;
	wire [6:0] aoff = akind ? arel - `TLA_ALARM_HIGH_REL : arel;
	wire in_alarm_area = link.addr >= `TLA_ALARM_BASE && link.addr <= `TLA_ALARM_END;
	wire [6:0] sp_pos = {2'b00, ta[4:0]} + {1'b0, link.addr[5:0]} - {1'b0, `TLA_SP_PREAMBLE};
	logic [7:0] mem_rd, sp_rd;
	always_comb begin
		mem_rd = 8'h00;
		if (in_alarm_area) begin
			mem_rd = alarm_mem[akind][aoff[5:0]];
		end else begin
			unique case (link.addr)
				`TLA_REG_TH_LOW: mem_rd = th_low;
				`TLA_REG_TH_HIGH: mem_rd = th_high;
				`TLA_REG_RATE: mem_rd = srate;
				`TLA_REG_CTRL: mem_rd = ctrl;
				`TLA_REG_DELAY_LO: mem_rd = delay_lo;
				`TLA_REG_DELAY_HI: mem_rd = delay_hi;
				`TLA_REG_STATUS: mem_rd = {1'b0, cleared_flag, mission_active, 3'b000,
					flag_high, flag_low};
				`TLA_REG_STAMP: mem_rd = stamp[7:0];
				`TLA_REG_STAMP + 16'd1: mem_rd = stamp[15:8];
				`TLA_REG_STAMP + 16'd2: mem_rd = stamp[23:16];
				`TLA_REG_STAMP + 16'd3: mem_rd = stamp[31:24];
				`TLA_REG_MCNT: mem_rd = mcnt[7:0];
				`TLA_REG_MCNT + 16'd1: mem_rd = mcnt[15:8];
				`TLA_REG_MCNT + 16'd2: mem_rd = mcnt[23:16];
				`TLA_REG_DCNT: mem_rd = dcnt[7:0];
				`TLA_REG_DCNT + 16'd1: mem_rd = dcnt[15:8];
				`TLA_REG_DCNT + 16'd2: mem_rd = dcnt[23:16];
				default: mem_rd = 8'h00;
			endcase
		end
		// Preamble TA low, TA high, status, then data up to the top byte
		if (link.addr[5:0] == 6'h00) sp_rd = ta[7:0];
		else if (link.addr[5:0] == 6'h01) sp_rd = ta[15:8];
		else if (link.addr[5:0] == 6'h02) sp_rd = es_byte;
		else if (sp_pos <= 7'h1f) sp_rd = sp[sp_pos[4:0]];
		else sp_rd = 8'hff;
	end

	// Scratchpad writes and the transfer status byte
	always_ff @(posedge i_clk_sys) begin
		if (do_spdata) sp[wptr[4:0]] <= link.data;
	end
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ta <= 16'h0000;
			es_off <= 5'h00;
			wptr <= 6'h00;
			pf <= 1'b0;
			aa <= 1'b0;
		end else begin
			if (do_wrsp || do_rdmem) ta <= link.addr;
			if (do_wrsp) begin
				wptr <= {1'b0, link.addr[4:0]};
				es_off <= link.addr[4:0];
				pf <= 1'b0;
				aa <= 1'b0;
			end
			if (do_spdata) begin
				es_off <= wptr[4:0];
				wptr <= wptr + 6'd1;
				aa <= 1'b0;
			end
			if (do_sppart) pf <= 1'b1;
			if (do_copy) aa <= 1'b1;
		end
	end

	// Copy engine walks from the start offset to the ending offset
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			copying <= 1'b0;
			cptr <= 5'h00;
			caddr <= 16'h0000;
		end else if (do_copy) begin
			copying <= 1'b1;
			cptr <= ta[4:0];
			caddr <= ta;
		end else if (copying) begin
			copying <= cptr != es_off;
			cptr <= cptr + 5'd1;
			caddr <= caddr + 16'd1;
		end
	end

	// Register page; alarm flags: hardware set wins over a written clear
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			th_low <= 8'h00;
			th_high <= 8'h00;
			ctrl <= 8'h00;
			flag_low <= 1'b0;
			flag_high <= 1'b0;
		end else begin
			if (cwr && caddr == `TLA_REG_TH_LOW) th_low <= cwd;
			if (cwr && caddr == `TLA_REG_TH_HIGH) th_high <= cwd;
			if (cwr && caddr == `TLA_REG_CTRL) ctrl <= cwd;
			flag_low <= (sample && hit[0]) || (flag_low && !(wr_status && !cwd[`TLA_ST_LOW]));
			flag_high <= (sample && hit[1]) || (flag_high && !(wr_status && !cwd[`TLA_ST_HIGH]));
		end
	end

	// Minute divider and free-running minute clock
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			min_cnt <= 36'h0;
			rtc_min <= 32'h0;
		end else if (osc_run) begin
			min_cnt <= tick ? 36'h0 : min_cnt + 36'd1;
			if (tick) rtc_min <= rtc_min + 32'd1;
		end
	end

	// Mission sequencer; clear-memory only acts between missions
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			mstate <= TLA_IDLE;
			mission_active <= 1'b0;
			cleared_flag <= 1'b0;
			srate <= 8'h00;
			delay_lo <= 8'h00;
			delay_hi <= 8'h00;
			delay_cnt <= 16'h0;
			rate_cnt <= 8'h00;
			stamp <= 32'h0;
			mcnt <= 24'h0;
			dcnt <= 24'h0;
		end else begin
			if (do_clear) begin
				cleared_flag <= 1'b1;
				srate <= 8'h00;
				delay_lo <= 8'h00;
				delay_hi <= 8'h00;
				stamp <= 32'h0;
				mcnt <= 24'h0;
			end
			if (cwr && caddr == `TLA_REG_DELAY_LO) delay_lo <= cwd;
			if (cwr && caddr == `TLA_REG_DELAY_HI) delay_hi <= cwd;
			if (wr_rate) srate <= cwd;
			if (start) begin
				mission_active <= 1'b1;
				cleared_flag <= 1'b0;
				mstate <= TLA_DELAY;
				delay_cnt <= {delay_hi, delay_lo};
			end else if (end_mission) begin
				mission_active <= 1'b0;
				mstate <= TLA_IDLE;
			end else if (tick) begin
				unique case (mstate)
					TLA_IDLE: mstate <= TLA_IDLE;
					TLA_DELAY: if (delay_cnt != 16'h0) delay_cnt <= delay_cnt - 16'd1;
					TLA_RUN: if (rate_cnt != 8'h01) rate_cnt <= rate_cnt - 8'd1;
					default: mstate <= TLA_IDLE;
				endcase
			end
			if (sample && !end_mission) begin
				mcnt <= next_mcnt;
				dcnt <= dcnt + 24'd1;
				rate_cnt <= srate;
				if (first) begin
					stamp <= rtc_min;
					mstate <= TLA_RUN;
				end
			end
		end
	end

	// Alarm record area, one lane per kind: 0 low, 1 high
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < 2; k++) begin
				idx[k] <= 4'h0;
				in_alarm[k] <= 1'b0;
				for (int i = 0; i < AB; i++) alarm_mem[k][i] <= 8'h00;
			end
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (do_clear) begin
					idx[k] <= 4'h0;
					in_alarm[k] <= 1'b0;
					for (int i = 0; i < AB; i++) alarm_mem[k][i] <= 8'h00;
				end else if (sample && !end_mission) begin
					if (!hit[k]) begin
						in_alarm[k] <= 1'b0;
					end else if (!in_alarm[k] || dur_full[k]) begin
						// Only an opened entry may count on; with the area full the
						// last frozen entry must not resume counting
						if (idx[k] < ENTRIES[3:0]) begin
							in_alarm[k] <= 1'b1;
							alarm_mem[k][open_base[k]] <= next_mcnt[7:0];
							alarm_mem[k][open_base[k] + 6'd1] <= next_mcnt[15:8];
							alarm_mem[k][open_base[k] + 6'd2] <= next_mcnt[23:16];
							alarm_mem[k][open_base[k] + 6'd3] <= 8'h01;
							idx[k] <= idx[k] + 4'd1;
						end
					end else if (idx[k] != 4'h0) begin
						alarm_mem[k][cur_base[k] + 6'd3] <= alarm_mem[k][cur_base[k] + 6'd3] + 8'd1;
					end
				end
			end
		end
	end

	// Responses one cycle after a read; user-side outputs registered
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			o_sample <= 1'b0;
			o_mission_active <= 1'b0;
			o_search_hit <= 1'b0;
		end else begin
			rsp_valid <= do_rdmem || do_rdsp;
			rsp_data <= do_rdsp ? sp_rd : mem_rd;
			o_sample <= sample && !end_mission;
			o_mission_active <= mission_active;
			o_search_hit <= (ctrl[`TLA_CTRL_SRCH_LOW] && flag_low) ||
				(ctrl[`TLA_CTRL_SRCH_HIGH] && flag_high);
		end
	end

	assign link.rsp_valid = rsp_valid;
	assign link.rsp_data = rsp_data;
	assign link.busy = copying;
endmodule // tla_device
`default_nettype wire

// ===== hdl/tla_host.sv
// Bus master end: software loads address, data and a command, and the
// end issues it on the link once the logger is not busy.
// Assumes software keeps the mission set-up order itself.
`include "tla_consts.svh"
`default_nettype none
module tla_host import tla_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	tla_link_if.host link,
	input wire logic [2:0] i_sw_addr,
	input wire logic [15:0] i_sw_wdata,
	input wire logic i_sw_wr,
	input wire logic i_sw_rd,
	output logic [15:0] o_sw_rdata
);
	logic [15:0] addr_reg;
	logic [7:0] data_reg, resp;
	tla_cmd_t cmd_reg;
	logic pending, resp_new, req;
	tla_cmd_t cmd_out;
	logic [15:0] addr_out;
	logic [7:0] data_out;

	// Software port decode
	wire wr_addr = i_sw_wr && i_sw_addr == `TLA_HOST_ADDR;
	wire wr_data = i_sw_wr && i_sw_addr == `TLA_HOST_DATA;
	wire wr_cmd = i_sw_wr && i_sw_addr == `TLA_HOST_CMD;
	wire rd_resp = i_sw_rd && i_sw_addr == `TLA_HOST_RESP;
	// No issue right after a request: busy shows one cycle late
	wire issue = pending && !link.busy && !req;
	logic [15:0] rd_mux;
	always_comb begin
		unique case (i_sw_addr)
			`TLA_HOST_ADDR: rd_mux = addr_reg;
			`TLA_HOST_DATA: rd_mux = {8'h00, data_reg};
			`TLA_HOST_CMD: rd_mux = {13'h0000, cmd_reg};
			`TLA_HOST_RESP: rd_mux = {8'h00, resp};
			`TLA_HOST_STATUS: rd_mux = {13'h0000, link.busy, resp_new, pending};
			default: rd_mux = 16'h0000;
		endcase
	end

	// Order registers; a command write other than NOP arms one link request
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			addr_reg <= 16'h0000;
			data_reg <= 8'h00;
			cmd_reg <= TLA_NOP;
			pending <= 1'b0;
		end else begin
			if (wr_addr) addr_reg <= i_sw_wdata;
			if (wr_data) data_reg <= i_sw_wdata[7:0];
			if (wr_cmd) cmd_reg <= tla_cmd_t'(i_sw_wdata[2:0]);
			if (wr_cmd) pending <= i_sw_wdata[2:0] != TLA_NOP;
			else if (issue) pending <= 1'b0;
		end
	end

	// Link request pulse; clear and copy orders pass unchanged
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			req <= 1'b0;
			cmd_out <= TLA_NOP;
			addr_out <= 16'h0000;
			data_out <= 8'h00;
		end else begin
			req <= issue;
			if (issue) begin
				cmd_out <= cmd_reg;
				addr_out <= addr_reg;
				data_out <= data_reg;
			end
		end
	end

	// Response capture; a new answer wins over a clearing read
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			resp <= 8'h00;
			resp_new <= 1'b0;
			o_sw_rdata <= 16'h0000;
		end else begin
			if (link.rsp_valid) resp <= link.rsp_data;
			resp_new <= link.rsp_valid || (resp_new && !rd_resp);
			o_sw_rdata <= i_sw_rd ? rd_mux : 16'h0000;
		end
	end

	assign link.req = req;
	assign link.cmd = cmd_out;
	assign link.addr = addr_out;
	assign link.data = data_out;
endmodule // tla_host
`default_nettype wire

// ===== testbench/tla_link_asserts.sv
// Checker for the link between the master end and the logger end.
// Assumes the bench hands it the interface signals by name.
`default_nettype none
module tla_link_asserts import tla_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic req,
	input wire tla_cmd_t cmd,
	input wire logic [15:0] addr,
	input wire logic [7:0] data,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic busy
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	logic [15:0] ta;
	logic [5:0] idx;
	logic last_rdsp;
	// Accepted requests; anything sent while busy is dropped by the logger
	wire acc = req && !busy;
	wire rd_acc = acc && (cmd == TLA_RDMEM || cmd == TLA_RDSP);
	wire cp_acc = acc && cmd == TLA_COPY;
	wire st_rd = rsp_valid && last_rdsp;
	wire [6:0] sp_pos = {2'b00, ta[4:0]} + {1'b0, idx} - 7'h03;
	// Shadow of the target address and of the last preamble index
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ta <= 16'h0000;
			idx <= 6'h00;
			last_rdsp <= 1'b0;
		end else if (acc) begin
			if (cmd == TLA_WRSP || cmd == TLA_RDMEM) ta <= addr;
			idx <= addr[5:0];
			last_rdsp <= cmd == TLA_RDSP;
		end
	end
	property p_rsp_after_rd; rd_acc |=> rsp_valid; endproperty
	a_rsp_after_rd: assert property (p_rsp_after_rd) else $error("read not answered");
	property p_rsp_cause; rsp_valid |-> $past(rd_acc); endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("answer without read");
	property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
	property p_req_gap; req |=> !req; endproperty
	a_req_gap: assert property (p_req_gap) else $error("requests back to back");
	property p_ta_lo; st_rd && idx == 6'h00 |-> rsp_data == ta[7:0]; endproperty
	a_ta_lo: assert property (p_ta_lo) else $error("target low wrong");
	property p_ta_hi; st_rd && idx == 6'h01 |-> rsp_data == ta[15:8]; endproperty
	a_ta_hi: assert property (p_ta_hi) else $error("target high wrong");
	property p_bit6; st_rd && idx == 6'h02 |-> !rsp_data[6]; endproperty
	a_bit6: assert property (p_bit6) else $error("status bit 6 set");
	property p_pad; st_rd && idx >= 6'h03 && sp_pos > 7'h1f |-> rsp_data == 8'hff; endproperty
	a_pad: assert property (p_pad) else $error("read past scratchpad end");
	property p_busy_cause; $rose(busy) |-> $past(cp_acc); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without copy");
	property p_busy_len; busy |-> ##[1:40] !busy; endproperty
	a_busy_len: assert property (p_busy_len) else $error("copy never ends");
endmodule // tla_link_asserts
`default_nettype wire

// ===== testbench/tb.sv
// Bench: software port of the master end drives the logger end.
// Assumes a 200 MHz clock and a minute shortened to 20 cycles.
`default_nettype none
module tb import tla_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MIN_CYC = 20;
	localparam int RATE = 2;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] sw_addr = 3'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [15:0] sw_rdata;
	logic [7:0] temp = 8'h80;
	logic smp;
	logic act;
	logic hit;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int n_samp = 0;
	int last_smp = 0;
	logic [7:0] r;
	logic [15:0] st16;
	logic [7:0] sd [5];
	logic [7:0] exp_tab [20] = '{8'h02, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'hff, 8'h06, 8'h01, 8'h00, 8'h02};
	tla_link_if tla_link_if_inst ();
	tla_host tla_host_inst (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.link(tla_link_if_inst),
		.i_sw_addr(sw_addr),
		.i_sw_wdata(sw_wdata),
		.i_sw_wr(sw_wr),
		.i_sw_rd(sw_rd),
		.o_sw_rdata(sw_rdata)
	);
	tla_device #(.MINUTE_CYCLES(MIN_CYC)) tla_device_inst (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.link(tla_link_if_inst),
		.i_temp(temp),
		.o_sample(smp),
		.o_mission_active(act),
		.o_search_hit(hit)
	);
	tla_link_asserts tla_link_asserts_inst (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.req(tla_link_if_inst.req),
		.cmd(tla_link_if_inst.cmd),
		.addr(tla_link_if_inst.addr),
		.data(tla_link_if_inst.data),
		.rsp_valid(tla_link_if_inst.rsp_valid),
		.rsp_data(tla_link_if_inst.rsp_data),
		.busy(tla_link_if_inst.busy)
	);
	// Temperature plan: low run 2-4 and 6, high run 7-263 to overflow a counter
	function automatic logic [7:0] temp_for(input int k);
		if (k == 2) return 8'h40;
		if (k == 7) return 8'hc0;
		if ((k > 2 && k < 5) || k == 6) return 8'($urandom_range(8'h3f, 8'h00));
		if (k > 7 && k < 264) return 8'($urandom_range(8'hff, 8'hc1));
		return 8'($urandom_range(8'hbf, 8'h41));
	endfunction
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic sw_wr_t(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge i_clk_sys);
		sw_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic sw_rd_t(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_clk_sys);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge i_clk_sys);
		sw_rd <= 1'b0;
		@(negedge i_clk_sys);
		d = sw_rdata;
	endtask
	// One link order; polls status so a slow copy never gets overrun
	task automatic link(input tla_cmd_t c, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] st;
		sw_wr_t(3'h0, a);
		sw_wr_t(3'h1, {8'h00, d});
		sw_wr_t(3'h2, {13'h0000, c});
		st = 16'h0007;
		for (int i = 0; i < 50 && (st[0] || st[2] ||
			(c inside {TLA_RDMEM, TLA_RDSP} && !st[1])); i++)
			sw_rd_t(3'h4, st);
		// A poll limit that runs out is a failure of its own
		if (st[0] || st[2] || (c inside {TLA_RDMEM, TLA_RDSP} && !st[1])) begin
			n_mismatch++;
			$display("ERROR %0t: link order never finished", $time);
		end
		sw_rd_t(3'h3, st);
		q = st[7:0];
	endtask
	task automatic lk_chk(input tla_cmd_t c, input logic [15:0] a, input logic [7:0] e);
		logic [7:0] q;
		link(c, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] es;
		link(TLA_WRSP, a, 8'h00, es);
		link(TLA_SPDATA, 16'h0000, d, es);
		link(TLA_RDSP, 16'h0002, 8'h00, es);
		link(TLA_COPY, a, es, es);
		lk_chk(TLA_RDSP, 16'h0002, {3'b100, a[4:0]});
	endtask
	initial begin
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	// Timeout and sample pacing; next temperature is set just after a sample
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
		if (smp) begin
			n_samp++;
			if (n_samp > 1) chk(8'(cyc - last_smp), 8'(RATE * MIN_CYC));
			last_smp = cyc;
			temp <= temp_for(n_samp + 1);
		end
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		void'($urandom(32'h7565));
		sw_rd_t(3'h5, st16);
		chk({7'h00, |st16}, 8'h00);
		for (int i = 0; i < 5; i++) sd[i] = 8'($urandom);
		link(TLA_WRSP, 16'h013c, 8'h00, r);
		for (int i = 0; i < 5; i++) link(TLA_SPDATA, 16'h0000, sd[i], r);
		lk_chk(TLA_RDSP, 16'h0000, 8'h3c);
		lk_chk(TLA_RDSP, 16'h0001, 8'h01);
		lk_chk(TLA_RDSP, 16'h0002, 8'h1f);
		for (int i = 0; i < 4; i++) lk_chk(TLA_RDSP, 16'(i + 3), sd[i]);
		lk_chk(TLA_RDSP, 16'h0007, 8'hff);
		link(TLA_WRSP, 16'h0100, 8'h00, r);
		link(TLA_SPDATA, 16'h0000, sd[0], r);
		link(TLA_SPPART, 16'h0000, sd[1], r);
		lk_chk(TLA_RDSP, 16'h0002, 8'h20);
		link(TLA_CLEAR, 16'h0000, 8'h00, r);
		lk_chk(TLA_RDMEM, 16'h0214, 8'h40);
		wr_mem(16'h020e, 8'h13);
		wr_mem(16'h020d, 8'(RATE));
		@(posedge i_clk_sys);
		chk({7'h00, act}, 8'h00);
		wr_mem(16'h020b, 8'h40);
		wr_mem(16'h020c, 8'hc0);
		wr_mem(16'h0212, 8'h00);
		wr_mem(16'h0213, 8'h00);
		wr_mem(16'h020e, 8'h03);
		temp <= temp_for(1);
		wr_mem(16'h020d, 8'(RATE));
		@(posedge i_clk_sys);
		chk({7'h00, act}, 8'h01);
		lk_chk(TLA_RDMEM, 16'h0214, 8'h20);
		for (int i = 0; i < 15000 && n_samp < 265; i++) @(posedge i_clk_sys);
		if (n_samp < 265) begin
			n_mismatch++;
			$display("ERROR %0t: samples stopped at %0d", $time, n_samp);
		end
		// A clear order during a mission is refused and must spare the records
		link(TLA_CLEAR, 16'h0000, 8'h00, r);
		for (int i = 0; i < 20; i++)
			lk_chk(TLA_RDMEM, 16'(i < 12 ? 16'h0220 + i : 16'h0244 + i), exp_tab[i]);
		lk_chk(TLA_RDMEM, 16'h0214, 8'h23);
		chk({7'h00, hit}, 8'h01);
		// Copy into the protected page during a mission ends it and writes nothing
		wr_mem(16'h020b, 8'h11);
		lk_chk(TLA_RDMEM, 16'h020b, 8'h40);
		lk_chk(TLA_RDMEM, 16'h0214, 8'h03);
		chk({7'h00, act}, 8'h00);
		summarize();
	end
endmodule // tb
`default_nettype wire
